// ---- design/cis_priority.sv ----
`timescale 1ns/100ps
// Fixed priority picker: lowest index (lowest vector) wins.
module cis_priority
  import cis_pkg::*;
(
  input wire logic [NUM_SRC-1:0] i_request,
  output logic o_any,
  output logic [2:0] o_index
);
  always_comb
  begin
    o_any = 1'b0;
    o_index = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (i_request[i])
      begin
        o_any = 1'b1;
        o_index = 3'(i);
      end
    end
  end
endmodule : cis_priority

// ---- design/cis_sequencer.sv ----
`timescale 1ns/100ps
// Interrupt entry and return sequencer with stack pointer and config guard.
module cis_sequencer
  import cis_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire cis_core_t i_core,
  input wire cis_io_t i_io,
  input wire logic [NUM_SRC-1:0] i_event,
  input wire logic [NUM_SRC-1:0] i_level,
  output logic [7:0] o_rdata,
  output logic o_global_enable,
  output logic o_stall,
  output logic o_vector_valid,
  output logic [2:0] o_vector,
  output logic o_push_pc,
  output logic o_pop_pc,
  output logic o_resume,
  output logic o_guard_open,
  output logic o_protected_write_ok,
  output logic [SP_BITS-1:0] o_stack_pointer
);
  // The core clock is used as is; no divider exists in this block.
  // ALU timing lives in the datapath; boundary marks a completed instruction.

  typedef enum {ST_RUN, ST_WAKE, ST_ENTRY, ST_RETURN} cis_state_t;
  cis_state_t state;
  logic [2:0] count;
  logic [7:0] flags;
  logic [7:0] enables;
  logic global_enable;
  logic hold_one;
  logic [2:0] guard_count;
  logic [SP_BITS-1:0] sp;
  logic [NUM_SRC-1:0] request;
  logic any_req;
  logic [2:0] pick;
  logic take;
  logic guard_hit;
  logic [7:0] flag_clear_sw;
  logic [7:0] flag_clear_hw;

  function automatic logic io_wr(input cis_io_t io, input logic [5:0] a);
    io_wr = io.write && io.addr == a;
  endfunction : io_wr

  // ---------------------------------------------------------------
  // Request gating
  // ---------------------------------------------------------------
  // Level sources bypass the flag store, so a vanished level never fires.
  assign request = ((flags & ~LEVEL_TYPE_MASK) | (i_level & LEVEL_TYPE_MASK))
    & enables;

  cis_priority u_priority
  (
    .i_request(request),
    .o_any(any_req),
    .o_index(pick)
  );

  // Disable instruction in the same cycle blocks the take outright.
  assign take = state == ST_RUN && any_req && global_enable && !i_core.disable_instr
    && i_core.boundary && !i_core.multi_cycle_busy && !hold_one
    && guard_count == 3'h0 && !i_core.return_instr;

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  always_comb
  begin
    flag_clear_sw = io_wr(i_io, ADDR_FLAGS) ? i_io.wdata : 8'h00;
    flag_clear_hw = 8'h00;
    if (take)
    begin
      flag_clear_hw[pick] = 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      flags <= FLAGS_RESET;
    end
    else
    begin
      // A new event wins over either clear.
      flags <= ((flags & ~(flag_clear_sw | flag_clear_hw)) | i_event)
        & ~LEVEL_TYPE_MASK;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      enables <= ENABLES_RESET;
    end
    else if (io_wr(i_io, ADDR_ENABLES))
    begin
      enables <= i_io.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Global enable and instruction boundary holds
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      global_enable <= 1'b0;
    end
    else if (take)
    begin
      global_enable <= 1'b0;
    end
    else if (state == ST_RETURN && count == 3'h1)
    begin
      global_enable <= 1'b1;
    end
    else if (i_core.disable_instr)
    begin
      global_enable <= 1'b0;
    end
    else if (i_core.enable_instr)
    begin
      global_enable <= 1'b1;
    end
  end

  // After an enable or a return, the next instruction must finish first.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      hold_one <= 1'b0;
    end
    else if (i_core.enable_instr || (state == ST_RETURN && count == 3'h1))
    begin
      hold_one <= 1'b1;
    end
    else if (state == ST_RUN && i_core.boundary)
    begin
      hold_one <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Entry and return sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state <= ST_RUN;
      count <= 3'h0;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          if (take && i_core.asleep)
          begin
            state <= ST_WAKE;
            count <= WAKE_EXTRA_CYCLES;
          end
          else if (take)
          begin
            state <= ST_ENTRY;
            count <= ENTRY_CYCLES;
          end
          else if (i_core.return_instr)
          begin
            state <= ST_RETURN;
            count <= RETURN_CYCLES;
          end
        end
        ST_WAKE:
        begin
          if (count == 3'h1)
          begin
            state <= ST_ENTRY;
            count <= ENTRY_CYCLES;
          end
          else
          begin
            count <= count - 3'h1;
          end
        end
        ST_ENTRY, ST_RETURN:
        begin
          if (count == 3'h1)
          begin
            state <= ST_RUN;
          end
          count <= count - 3'h1;
        end
        default:
        begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_vector <= 3'h0;
    end
    else if (take)
    begin
      o_vector <= pick;
    end
  end

  // ---------------------------------------------------------------
  // Stack pointer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      sp <= SP_RESET;
    end
    else if ((state == ST_ENTRY && count == ENTRY_CYCLES) || i_core.call_instr)
    begin
      sp <= sp - RETURN_ADDR_BYTES;
    end
    else if ((state == ST_RETURN && count == RETURN_CYCLES) || i_core.ret_instr)
    begin
      sp <= sp + RETURN_ADDR_BYTES;
    end
    else if (io_wr(i_io, ADDR_SP_LOW))
    begin
      sp[7:0] <= i_io.wdata;
    end
    else if (io_wr(i_io, ADDR_SP_HIGH))
    begin
      sp[10:8] <= i_io.wdata[2:0];
    end
  end

  // ---------------------------------------------------------------
  // Configuration change guard
  // ---------------------------------------------------------------
  assign guard_hit = io_wr(i_io, ADDR_GUARD) && i_io.wdata == GUARD_SIGNATURE;

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      guard_count <= 3'h0;
    end
    else if (guard_hit)
    begin
      guard_count <= GUARD_WINDOW_CYCLES;
    end
    else if (guard_count != 3'h0 && i_core.boundary)
    begin
      guard_count <= guard_count - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Read data and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_io.read)
    begin
      if (i_io.addr == ADDR_SP_LOW)
        o_rdata <= sp[7:0];
      else if (i_io.addr == ADDR_SP_HIGH)
        o_rdata <= {5'h00, sp[10:8]};
      else if (i_io.addr == ADDR_GUARD)
        o_rdata <= {7'h00, guard_count != 3'h0};
      else if (i_io.addr == ADDR_FLAGS)
        o_rdata <= flags;
      else if (i_io.addr == ADDR_ENABLES)
        o_rdata <= enables;
      else
        o_rdata <= 8'h00;
    end
  end

  assign o_global_enable = global_enable;
  assign o_stall = state != ST_RUN;
  assign o_vector_valid = state == ST_ENTRY && count == 3'h1;
  assign o_push_pc = state == ST_ENTRY && count == ENTRY_CYCLES;
  assign o_pop_pc = state == ST_RETURN && count == RETURN_CYCLES;
  assign o_resume = state == ST_RETURN && count == 3'h1;
  assign o_guard_open = guard_count != 3'h0;
  assign o_protected_write_ok = guard_count != 3'h0;
  assign o_stack_pointer = sp;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence entry_run_s;
    state == ST_ENTRY [*4];
  endsequence

  gate_enable_a: assert property (@(posedge i_clock) disable iff (i_reset)
    take |-> global_enable && request[pick])
    else $error("Interrupt taken while gated off.");
  entry_length_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (take && !i_core.asleep) |=> entry_run_s ##1 state == ST_RUN)
    else $error("Entry did not last four cycles.");
  wake_length_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (take && i_core.asleep) |=> state == ST_WAKE [*4] ##1 entry_run_s)
    else $error("Wake entry missing four extra cycles.");
  entry_clear_a: assert property (@(posedge i_clock) disable iff (i_reset)
    take |=> !global_enable)
    else $error("Global enable not cleared on entry.");
  return_set_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (state == ST_RUN && i_core.return_instr && !take) |=> state == ST_RETURN [*4]
    ##1 (state == ST_RUN && global_enable && sp == $past(sp, 4) + RETURN_ADDR_BYTES))
    else $error("Return sequence wrong.");
  disable_now_a: assert property (@(posedge i_clock) disable iff (i_reset)
    i_core.disable_instr |-> !take)
    else $error("Interrupt taken with disable instruction.");
  guard_block_a: assert property (@(posedge i_clock) disable iff (i_reset)
    guard_count != 3'h0 |-> !take)
    else $error("Interrupt taken inside guard window.");
  guard_read_a: assert property (@(posedge i_clock) disable iff (i_reset)
    $past(i_io.read) && $past(i_io.addr) == ADDR_GUARD |-> o_rdata[7:1] == 7'h00)
    else $error("Guard upper bits not zero.");
  push_two_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_push_pc |=> sp == $past(sp) - RETURN_ADDR_BYTES)
    else $error("Push did not lower pointer by two.");
  after_return_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_resume |=> !take)
    else $error("Interrupt taken right after return.");
endmodule : cis_sequencer

// ---- include/cis_pkg.sv ----
// Package of constants and types for the CPU interrupt sequencer.
// Notes on behaviour
// - The core runs on the undivided chip clock; no internal clock division.
// - A two-register ALU operation reads, computes and writes back in one cycle.
// - A source is serviced only when its own enable and the global enable are set.
// - The lowest vector wins among pending requests; reset highest, then external request zero.
// - Taking an interrupt clears the global enable; software may set it again to nest.
// - The return-from-handler instruction sets the global enable.
// - Vectoring to a flag-type handler clears that pending flag in hardware.
// - Writing one to a flag position clears it; writing zero leaves it.
// - A flag request raised while disabled stays latched until enabled or cleared.
// - Level requests ask for service only while their condition is present.
// - After a return, one main-program instruction runs before any interrupt.
// - The global-disable instruction blocks interrupts at once, same-cycle requests included.
// - After the global-enable instruction, the next instruction completes before any interrupt.
// - Interrupt entry takes at least four cycles, pushing the program counter.
// - A request during a multi-cycle instruction waits until that instruction completes.
// - Waking from sleep adds four cycles to the entry response.
// - A return takes four cycles, pops two bytes, raises the stack pointer by two.
// - Signature 0xD8 unlocks protected registers for the next four instruction cycles.
// - Interrupts are ignored while the protection window is open.
// - The guard register reads one in bit 0 while open; bits 7 to 1 read zero.
// - The stack pointer is 11 bits, grows downward; upper five high-byte bits read zero.
// - Pushing a return address lowers the stack pointer by two.
// - Hardware clears the global enable on entry; return sets it.
package cis_pkg;
  localparam int NUM_SRC = 8;
  localparam int SP_BITS = 11;
  localparam logic [5:0] ADDR_SP_LOW = 6'h3D;
  localparam logic [5:0] ADDR_SP_HIGH = 6'h3E;
  localparam logic [5:0] ADDR_GUARD = 6'h3C;
  localparam logic [5:0] ADDR_FLAGS = 6'h3B;
  localparam logic [5:0] ADDR_ENABLES = 6'h3A;
  localparam logic [7:0] GUARD_SIGNATURE = 8'hD8;
  localparam logic [10:0] SP_RESET = 11'h4FF;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] LEVEL_TYPE_MASK = 8'hC0;
  localparam logic [2:0] GUARD_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] ENTRY_CYCLES = 3'h4;
  localparam logic [2:0] WAKE_EXTRA_CYCLES = 3'h4;
  localparam logic [2:0] RETURN_CYCLES = 3'h4;
  localparam logic [10:0] RETURN_ADDR_BYTES = 11'h002;
  localparam int CLOCK_PERIOD_NS = 10;

  typedef struct packed {
    logic boundary;
    logic multi_cycle_busy;
    logic enable_instr;
    logic disable_instr;
    logic return_instr;
    logic call_instr;
    logic ret_instr;
    logic asleep;
  } cis_core_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cis_io_t;
endpackage : cis_pkg

// ---- testbench/cis_request_model.sv ----
// Peripheral request model: one-cycle flag events and held level conditions.
`timescale 1ns/100ps
module cis_request_model
  import cis_pkg::*;
(
  input wire logic i_fire_en,
  input wire logic [2:0] i_fire,
  input wire logic [NUM_SRC-1:0] i_level_on,
  output logic [NUM_SRC-1:0] o_event,
  output logic [NUM_SRC-1:0] o_level
);
  // Flag sources only pulse, so a late enable must rely on the latched flag.
  assign o_event = i_fire_en ? ((NUM_SRC'(1) << i_fire) & ~LEVEL_TYPE_MASK) : '0;
  assign o_level = i_level_on & LEVEL_TYPE_MASK;
endmodule : cis_request_model

// ---- testbench/cis_sequencer_tb.sv ----
// Self-checking testbench for the interrupt sequencer.
`timescale 1ns/100ps
module cis_sequencer_tb
  import cis_pkg::*;
;
  typedef struct packed {logic w; logic [5:0] a; logic [7:0] d; logic [7:0] e;} cis_row_t;
  logic clock, reset, fire_en, ge, stall, vvalid, push, pop, resume, gopen, pwok;
  logic [2:0] fire, vec;
  logic [NUM_SRC-1:0] level_on, ev, lv;
  logic [7:0] rdata, q;
  logic [SP_BITS-1:0] sp, sp0;
  cis_core_t core;
  cis_io_t io;
  int err_total = 0;
  int samples_checked = 0;
  int n;
  cis_row_t rows [12] = '{
    '{1'b0, ADDR_SP_LOW, 8'h00, SP_RESET[7:0]}, '{1'b0, ADDR_SP_HIGH, 8'h00, {5'h00, SP_RESET[10:8]}},
    '{1'b1, ADDR_SP_HIGH, 8'hFF, 8'h00}, '{1'b0, ADDR_SP_HIGH, 8'h00, 8'h07},
    '{1'b1, ADDR_SP_LOW, 8'hA5, 8'h00}, '{1'b0, ADDR_SP_LOW, 8'h00, 8'hA5},
    '{1'b1, ADDR_SP_HIGH, 8'h04, 8'h00}, '{1'b1, ADDR_SP_LOW, 8'hFF, 8'h00},
    '{1'b0, ADDR_GUARD, 8'h00, 8'h00}, '{1'b1, ADDR_GUARD, 8'h55, 8'h00},
    '{1'b0, ADDR_GUARD, 8'h00, 8'h00}, '{1'b1, ADDR_ENABLES, 8'hFF, 8'h00}};

  cis_sequencer i_cis_sequencer (.i_clock(clock), .i_reset(reset), .i_core(core), .i_io(io),
    .i_event(ev), .i_level(lv), .o_rdata(rdata), .o_global_enable(ge), .o_stall(stall),
    .o_vector_valid(vvalid), .o_vector(vec), .o_push_pc(push), .o_pop_pc(pop),
    .o_resume(resume), .o_guard_open(gopen), .o_protected_write_ok(pwok),
    .o_stack_pointer(sp));
  cis_request_model i_cis_request_model (.i_fire_en(fire_en), .i_fire(fire),
    .i_level_on(level_on), .o_event(ev), .o_level(lv));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check

  task stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task reg_op(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clock);
    io <= '{write: w, read: !w, addr: a, wdata: d};
    @(posedge clock);
    io <= '0;
    @(negedge clock);
    r = rdata;
  endtask : reg_op

  // Instruction pulse (0 enable, 1 disable, 2 return) with an optional event in the same cycle.
  task pulse(input int which, input int src);
    @(posedge clock);
    core.enable_instr <= (which == 0);
    core.disable_instr <= (which == 1);
    core.return_instr <= (which == 2);
    fire_en <= (src >= 0);
    fire <= src[2:0];
    @(posedge clock);
    core.enable_instr <= 1'b0;
    core.disable_instr <= 1'b0;
    core.return_instr <= 1'b0;
    fire_en <= 1'b0;
  endtask : pulse

  task wait_for(input int which, output int cnt);
    logic seen;
    cnt = 0;
    seen = 1'b0;
    while (seen !== 1'b1 && cnt < 40)
    begin
      @(negedge clock);
      cnt++;
      seen = (which == 1) ? vvalid : (which == 2) ? pop : (which == 3) ? resume : stall;
    end
    check(seen, 1'b1, "awaited output never came");
  endtask : wait_for

  task quiet(input int cycles);
    repeat (cycles)
    begin
      @(negedge clock);
      check(stall, 1'b0, "unexpected entry");
    end
  endtask : quiet

  // Follows one entry and its return; level and sleep inputs drop before the return.
  task handle(input logic [2:0] want, input int len, output int n_start);
    int cnt;
    wait_for(4, n_start);
    check(vec, want, "vector");
    check(ge, 1'b0, "enable on entry");
    sp0 = sp;
    wait_for(1, cnt);
    check(16'(cnt), 16'(len), "entry length");
    check(sp, sp0 - 11'h002, "sp after push");
    @(posedge clock);
    level_on <= '0;
    core.asleep <= 1'b0;
    // The stand-in handler alters no status flags, so it has nothing to save.
    pulse(2, -1);
    wait_for(2, cnt);
    check(16'(cnt), 16'd1, "pop start");
    wait_for(3, cnt);
    check(16'(cnt), 16'd3, "return length");
    @(negedge clock);
    check(ge, 1'b1, "enable on return");
    check(sp, sp0, "sp after pop");
    check(stall, 1'b0, "entry before main instruction");
  endtask : handle

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    reset = 1'b1;
    fire_en = 1'b0;
    fire = 3'h0;
    level_on = '0;
    io = '0;
    core = '0;
    core.boundary = 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check(ge, 1'b0, "reset enable");
    check(sp, SP_RESET, "reset sp");
    foreach (rows[i])
    begin
      reg_op(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w)
        check(q, rows[i].e, "register read");
    end
    check(pwok, 1'b0, "locked write");
    $display("test registers done");
    pulse(3, 3);
    pulse(3, 1);
    quiet(4);
    pulse(0, -1);
    handle(3'h1, 3, n);
    check(n >= 2, 1'b1, "entry after enable");
    handle(3'h3, 3, n);
    $display("test priority done");
    // A level request rises in the very cycle of the disable instruction.
    @(posedge clock);
    core.disable_instr <= 1'b1;
    level_on <= 8'h80;
    pulse(1, 2);
    quiet(6);
    check(ge, 1'b0, "disable");
    reg_op(1'b1, ADDR_FLAGS, 8'hFB, q);
    pulse(0, -1);
    handle(3'h2, 3, n);
    pulse(1, 4);
    reg_op(1'b1, ADDR_FLAGS, 8'h10, q);
    pulse(0, -1);
    quiet(6);
    $display("test disable done");
    pulse(1, -1);
    @(posedge clock);
    level_on <= 8'h40;
    repeat (3) @(posedge clock);
    level_on <= 8'h00;
    pulse(0, -1);
    quiet(6);
    @(posedge clock);
    level_on <= 8'h40;
    handle(3'h6, 3, n);
    $display("test level done");
    @(posedge clock);
    core.multi_cycle_busy <= 1'b1;
    core.boundary <= 1'b0;
    pulse(3, 0);
    quiet(4);
    @(posedge clock);
    core.multi_cycle_busy <= 1'b0;
    core.boundary <= 1'b1;
    handle(3'h0, 3, n);
    @(posedge clock);
    core.asleep <= 1'b1;
    pulse(3, 5);
    handle(3'h5, 7, n);
    $display("test timing done");
    @(posedge clock);
    core.boundary <= 1'b0;
    reg_op(1'b1, ADDR_GUARD, GUARD_SIGNATURE, q);
    check(gopen, 1'b1, "window open");
    check(pwok, 1'b1, "protected write allowed");
    reg_op(1'b0, ADDR_GUARD, 8'h00, q);
    check(q, 8'h01, "guard read open");
    pulse(3, 0);
    quiet(5);
    check(gopen, 1'b1, "window counts boundaries");
    @(posedge clock);
    core.boundary <= 1'b1;
    handle(3'h0, 3, n);
    check(n >= 5, 1'b1, "entry held for window");
    check(gopen, 1'b0, "window closed");
    $display("test guard done");
    sp0 = sp;
    @(posedge clock);
    core.call_instr <= 1'b1;
    @(posedge clock);
    core.call_instr <= 1'b0;
    core.ret_instr <= 1'b1;
    @(negedge clock);
    check(sp, sp0 - 11'h002, "sp after call");
    @(posedge clock);
    core.ret_instr <= 1'b0;
    @(negedge clock);
    check(sp, sp0, "sp after ret");
    reg_op(1'b1, ADDR_ENABLES, 8'h00, q);
    pulse(3, 4);
    quiet(4);
    reg_op(1'b1, ADDR_ENABLES, 8'hFF, q);
    handle(3'h4, 3, n);
    $display("test stack and enables done");
    reg_op(1'b1, ADDR_SP_LOW, 8'h10, q);
    reg_op(1'b1, ADDR_GUARD, GUARD_SIGNATURE, q);
    check(gopen, 1'b1, "window open before reset");
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check(ge, 1'b0, "enable after second reset");
    check(sp, SP_RESET, "sp after second reset");
    check(gopen, 1'b0, "window after second reset");
    check(stall, 1'b0, "state after second reset");
    $display("test reset done");
    stop_test();
  end

  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule : cis_sequencer_tb
